// [verilog/tape_drive_status_reporting.sv]
// Status bytes, error counters and tape position logic of the cartridge streamer
`timescale 1ns/1ps
`default_nettype none

module tape_drive_status_reporting (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Pins from the host bus and the hole sensors
  input wire logic hostResetPin,
  input wire logic onLinePin,
  input wire logic upper_hole_n,
  input wire logic lower_hole_n,
  // Drive controller state and events
  input wire logic trackZero,
  input wire logic writeActive,
  input wire logic readActive,
  input wire logic [6:2] firstByteCause,
  input wire tape_status_pkg::cmd_t cmd,
  input wire tape_status_pkg::drive_ev_t ev,
  // Status read port
  input wire logic rdStart,
  input wire logic rdByte,
  input wire logic [2:0] rdIndex,
  input wire logic rdDone,
  // Results
  output logic [7:0] statusByte,
  output logic statusParity,
  output logic statusValid,
  output logic exception,
  output tape_status_pkg::tape_pos_t tapePos
);
  import tape_status_pkg::*;

  // ----------------------------------------
  // Decoding helpers
  // ----------------------------------------
  // True when the command must be refused as illogical
  function automatic logic illegalCmd(input cmd_t c, input logic online, input logic wr, input logic rd);
    logic bad;
    bad = 1'b0;
    if (c.kind == CMD_SELECT && !$onehot(c.driveMask)) bad = 1'b1;
    if (c.kind == CMD_POSITION && c.qualifiers == '0) bad = 1'b1;
    if (!online && (c.kind == CMD_WRITE || c.kind == CMD_WFM || c.kind == CMD_READ || c.kind == CMD_RFM)) begin
      bad = 1'b1;
    end
    if (wr && !(c.kind == CMD_WRITE || c.kind == CMD_WFM)) bad = 1'b1;
    if (rd && !(c.kind == CMD_READ || c.kind == CMD_RFM)) bad = 1'b1;
    if (c.kind == CMD_UNIMPL) bad = 1'b1;
    return c.valid && bad;
  endfunction : illegalCmd

  // Saturating increment for the 16-bit counters
  function automatic logic [15:0] bump(input logic [15:0] v, input logic hit);
    return (hit && v != COUNT_MAX) ? v + 16'h0001 : v;
  endfunction : bump

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [3:0] syncA;
  logic [3:0] syncB;
  logic hostResetS;
  logic onLineS;
  logic upperS;
  logic lowerS;

  // Two stages for every pin
  always_ff @(posedge clk) begin
    if (rst) begin
      syncA <= 4'hF;
      syncB <= 4'hF;
    end else begin
      syncA <= {hostResetPin, onLinePin, upper_hole_n, lower_hole_n};
      syncB <= syncA;
    end
  end

  assign hostResetS = syncB[3];
  assign onLineS = syncB[2];
  assign upperS = syncB[1];
  assign lowerS = syncB[0];

  // ----------------------------------------
  // Tape position
  // ----------------------------------------
  logic windowSeen;
  logic next_windowSeen;
  tape_pos_t next_tapePos;
  logic atStart;

  // Hole code to position, windows remembered until next insertion
  always_comb begin
    next_windowSeen = windowSeen;
    if (ev.cartInserted) next_windowSeen = 1'b0;
    case ({upperS, lowerS})
      2'b00: begin
        next_tapePos = POS_START;
        next_windowSeen = 1'b1;
      end
      2'b10: begin
        next_tapePos = POS_END;
        next_windowSeen = 1'b1;
      end
      2'b01: next_tapePos = POS_WARNING;
      2'b11: next_tapePos = (windowSeen && !ev.cartInserted) ? POS_RECORD : POS_UNKNOWN;
      default: next_tapePos = POS_UNKNOWN;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      windowSeen <= 1'b0;
      tapePos <= POS_UNKNOWN;
    end else begin
      windowSeen <= next_windowSeen;
      tapePos <= next_tapePos;
    end
  end

  assign atStart = (tapePos == POS_START) && trackZero;

  // ----------------------------------------
  // Cause bits and exception
  // ----------------------------------------
  logic [7:0] cause0;
  logic [7:0] cause1;
  logic [7:0] next_cause0;
  logic [7:0] next_cause1;
  logic [7:0] snap0;
  logic [7:0] snap1;
  logic [7:0] next_snap0;
  logic [7:0] next_snap1;
  logic [5:0] idleBlocks;
  logic [5:0] next_idleBlocks;
  logic next_exception;
  logic [7:0] set0;
  logic [7:0] set1;
  logic [7:0] byte0;
  logic [7:0] byte1;

  // Sticky bits: clear only what the status read saw, a new set wins
  always_comb begin
    set0 = 8'h00;
    set1 = 8'h00;
    next_idleBlocks = idleBlocks;
    if (!readActive || ev.blockDetected) begin
      next_idleBlocks = 6'h00;
    end else if (ev.blockTimeTick && idleBlocks != NODATA_BLOCK_TIMES) begin
      next_idleBlocks = idleBlocks + 6'h01;
    end
    set1[ILLEGAL_BIT] = illegalCmd(cmd, onLineS, writeActive, readActive)
      || (ev.deselect && !atStart);
    set1[NODATA_BIT] = (next_idleBlocks == NODATA_BLOCK_TIMES) && (idleBlocks != NODATA_BLOCK_TIMES);
    set1[MARGINAL_BIT] = ev.marginalBlock;
    set1[POWERON_BIT] = hostResetS;
    set0[UNLOCATED_BIT] = ev.readErrUnlocated;
    set0[FILEMARK_BIT] = ev.filemarkRead && readActive;
    next_snap0 = rdStart ? cause0 : snap0;
    next_snap1 = rdStart ? cause1 : snap1;
    next_cause0 = (rdDone ? cause0 & ~snap0 : cause0) | set0;
    next_cause1 = (rdDone ? cause1 & ~snap1 : cause1) | set1;
    next_exception = (exception && !rdDone) || (set0 != 8'h00) || (set1 != 8'h00)
      || (firstByteCause != 5'h00);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cause0 <= BYTE_RESET;
      cause1 <= 8'h01;
      snap0 <= BYTE_RESET;
      snap1 <= BYTE_RESET;
      idleBlocks <= 6'h00;
      exception <= 1'b1;
    end else begin
      cause0 <= next_cause0;
      cause1 <= next_cause1;
      snap0 <= next_snap0;
      snap1 <= next_snap1;
      idleBlocks <= next_idleBlocks;
      exception <= next_exception;
    end
  end

  // Assembled exception bytes with their summary bits
  always_comb begin
    byte0 = {1'b0, firstByteCause, cause0[1:0]};
    byte0[SUMMARY_BIT] = byte0[6:0] != 7'h00;
    byte1 = cause1;
    byte1[MEDIASTART_BIT] = atStart;
    byte1[2:1] = 2'b00;
    byte1[SUMMARY_BIT] = byte1[6:0] != 7'h00;
  end

  // ----------------------------------------
  // Error and underrun counters
  // ----------------------------------------
  logic [15:0] errCount;
  logic [15:0] underrunCount;
  logic [15:0] next_errCount;
  logic [15:0] next_underrunCount;

  always_comb begin
    next_errCount = bump(errCount, (writeActive && ev.rewrittenBlock) || (readActive && ev.readRetry));
    next_underrunCount = bump(underrunCount, (writeActive || readActive) && ev.bufferUnderrun);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      errCount <= COUNT_RESET;
      underrunCount <= COUNT_RESET;
    end else begin
      errCount <= next_errCount;
      underrunCount <= next_underrunCount;
    end
  end

  // ----------------------------------------
  // Status byte output
  // ----------------------------------------
  logic [7:0] next_statusByte;
  logic next_statusParity;
  logic next_statusValid;
  logic [15:0] snapErr;
  logic [15:0] snapUnder;
  logic [7:0] snapB0;
  logic [7:0] snapB1;

  // Counters and cause bytes frozen at the start of the status read
  always_ff @(posedge clk) begin
    if (rst) begin
      snapErr <= COUNT_RESET;
      snapUnder <= COUNT_RESET;
      snapB0 <= BYTE_RESET;
      snapB1 <= BYTE_RESET;
    end else if (rdStart) begin
      snapErr <= errCount;
      snapUnder <= underrunCount;
      snapB0 <= byte0;
      snapB1 <= byte1;
    end
  end

  always_comb begin
    case (rdIndex)
      3'h0: next_statusByte = snapB0;
      3'h1: next_statusByte = snapB1;
      3'h2: next_statusByte = snapErr[15:8];
      3'h3: next_statusByte = snapErr[7:0];
      3'h4: next_statusByte = snapUnder[15:8];
      3'h5: next_statusByte = snapUnder[7:0];
      default: next_statusByte = 8'h00;
    endcase
    if (!rdByte) next_statusByte = statusByte;
    next_statusParity = ODD_PARITY ^ (^next_statusByte);
    next_statusValid = rdByte && (rdIndex < STATUS_BYTES);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      statusByte <= BYTE_RESET;
      statusParity <= ODD_PARITY;
      statusValid <= 1'b0;
    end else begin
      statusByte <= next_statusByte;
      statusParity <= next_statusParity;
      statusValid <= next_statusValid;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Closing strobe of a status read that saw the power-on bit, with no new reset pending
  sequence s_readDone;
    rdDone && snap1[POWERON_BIT] && !hostResetS;
  endsequence

  AST_SUMMARY1: assert property (byte1[SUMMARY_BIT] == (byte1[6:0] != 7'h00))
    else $error("second byte summary wrong");
  AST_SUMMARY0: assert property (byte0[SUMMARY_BIT] == (byte0[6:0] != 7'h00))
    else $error("first byte summary wrong");
  AST_ILLEGAL: assert property (cmd.valid && cmd.kind == CMD_UNIMPL |=> cause1[ILLEGAL_BIT])
    else $error("unimplemented command not flagged");
  AST_OFFLINE: assert property (cmd.valid && cmd.kind == CMD_READ && !onLineS |=> cause1[ILLEGAL_BIT])
    else $error("off line read not flagged");
  AST_NODATA: assert property (readActive && !ev.blockDetected && idleBlocks == 6'h1F && ev.blockTimeTick
    |=> cause1[NODATA_BIT])
    else $error("no data timeout missed");
  AST_MARGCLR: assert property (cause1[MARGINAL_BIT] && !ev.marginalBlock && !rdStart && rdDone && snap1[MARGINAL_BIT]
    |=> !cause1[MARGINAL_BIT])
    else $error("marginal bit not cleared by status read");
  AST_BOMONLY: assert property (!exception && atStart && firstByteCause == 5'h00 && set0 == 8'h00
    && set1 == 8'h00 |=> !exception)
    else $error("exception without cause");
  AST_EXCHOLD: assert property (exception && !rdDone |=> exception)
    else $error("exception dropped before status read");
  AST_FILEMARK: assert property (ev.filemarkRead && readActive |=> cause0[FILEMARK_BIT] ##0 exception)
    else $error("filemark not reported");
  AST_ERRCNT: assert property (writeActive && ev.rewrittenBlock && errCount != COUNT_MAX
    |=> errCount == $past(errCount) + 16'h0001)
    else $error("rewrite not counted");
  AST_UNDERRUN: assert property (readActive && ev.bufferUnderrun && underrunCount != COUNT_MAX
    |=> underrunCount == $past(underrunCount) + 16'h0001)
    else $error("underrun not counted");
  AST_PARITY: assert property (statusValid |-> (^{statusByte, statusParity}) == ODD_PARITY)
    else $error("status parity wrong");
  AST_POSRECORD: assert property (!windowSeen && upperS && lowerS |=> tapePos == POS_UNKNOWN)
    else $error("unknown position reported as recording");
  AST_PORCLR: assert property (s_readDone |=> !cause1[POWERON_BIT])
    else $error("power on bit not cleared by status read");

endmodule : tape_drive_status_reporting
`default_nettype wire

// [verilog/tape_status_pkg.sv]
// Constants, types and field layout for the tape drive status reporting block
package tape_status_pkg;

  // ----------------------------------------
  // Status byte layout
  // ----------------------------------------
  localparam int SUMMARY_BIT = 7;
  localparam int ILLEGAL_BIT = 6;
  localparam int NODATA_BIT = 5;
  localparam int MARGINAL_BIT = 4;
  localparam int MEDIASTART_BIT = 3;
  localparam int POWERON_BIT = 0;
  localparam int UNLOCATED_BIT = 1;
  localparam int FILEMARK_BIT = 0;
  localparam logic [2:0] STATUS_BYTES = 3'h6;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;

  // ----------------------------------------
  // Timing and widths
  // ----------------------------------------
  localparam logic [5:0] NODATA_BLOCK_TIMES = 6'h20;
  localparam int DRIVE_W = 4;
  localparam int QUAL_W = 5;
  localparam logic ODD_PARITY = 1'b1;

  // Command classes handed over by the command decoder
  typedef enum logic [3:0] {
    CMD_SELECT = 4'h0,
    CMD_POSITION = 4'h1,
    CMD_WRITE = 4'h2,
    CMD_WFM = 4'h3,
    CMD_READ = 4'h4,
    CMD_RFM = 4'h5,
    CMD_STATUS = 4'h6,
    CMD_OTHER = 4'h7,
    CMD_UNIMPL = 4'h8
  } cmd_kind_t;

  // Tape position codes
  typedef enum logic [2:0] {
    POS_UNKNOWN = 3'h0,
    POS_START = 3'h1,
    POS_END = 3'h2,
    POS_WARNING = 3'h3,
    POS_RECORD = 3'h4
  } tape_pos_t;

  // One accepted command
  typedef struct packed {
    logic valid;
    cmd_kind_t kind;
    logic [DRIVE_W-1:0] driveMask;
    logic [QUAL_W-1:0] qualifiers;
  } cmd_t;

  // One-cycle drive events
  typedef struct packed {
    logic filemarkRead;
    logic readErrUnlocated;
    logic marginalBlock;
    logic blockDetected;
    logic blockTimeTick;
    logic rewrittenBlock;
    logic readRetry;
    logic bufferUnderrun;
    logic deselect;
    logic cartInserted;
  } drive_ev_t;

endpackage : tape_status_pkg

// [sim/host_status_reader.sv]
// Host side model that fetches all six status bytes in one read
`timescale 1ns/1ps
`default_nettype none

module host_status_reader (
  // Clock and request from the bench
  input wire logic clk,
  input wire logic go,
  // Status read port toward the drive
  output logic rdStart,
  output logic rdByte,
  output logic [2:0] rdIndex,
  output logic rdDone,
  input wire logic [7:0] statusByte,
  input wire logic statusParity,
  input wire logic statusValid,
  // Results of the last read
  output logic [5:0][7:0] stat,
  output logic readOk,
  output logic done
);
  import tape_status_pkg::*;
  int i;

  // Start, six back to back fetches, then the closing strobe
  initial begin
    rdStart = 1'b0;
    rdByte = 1'b0;
    rdIndex = 3'h0;
    rdDone = 1'b0;
    stat = '0;
    readOk = 1'b1;
    done = 1'b1;
    forever begin
      @(posedge clk);
      if (go) begin
        done = 1'b0;
        readOk = 1'b1;
        @(negedge clk);
        rdStart = 1'b1;
        @(negedge clk);
        rdStart = 1'b0;
        rdByte = 1'b1;
        for (i = 0; i < 6; i++) begin
          rdIndex = 3'(i);
          @(negedge clk);
          stat[i] = statusByte;
          if (statusValid !== 1'b1 || ^{statusByte, statusParity} !== ODD_PARITY) readOk = 1'b0;
        end
        rdByte = 1'b0;
        rdDone = 1'b1;
        @(negedge clk);
        rdDone = 1'b0;
        @(posedge clk);
        done = 1'b1;
      end
    end
  end
endmodule : host_status_reader
`default_nettype wire

// [sim/tb_tape_drive_status_reporting.sv]
// Self-checking bench for the tape drive status reporting block
`timescale 1ns/1ps
`default_nettype none

module tb_tape_drive_status_reporting;
  import tape_status_pkg::*;
  typedef struct {
    logic [9:0] e;
    logic v;
    cmd_kind_t k;
    logic [3:0] m;
    logic [4:0] q;
    logic [2:0] lv;
    logic [7:0] b0;
    logic [7:0] b1;
    logic [7:0] ec;
    logic [7:0] uc;
  } row_t;
  logic clk = 1'b0, rst = 1'b1, hostResetPin = 1'b0, onLinePin = 1'b0, upper_hole_n = 1'b1, lower_hole_n = 1'b1;
  logic trackZero = 1'b0, writeActive = 1'b0, readActive = 1'b0, go = 1'b0;
  logic [6:2] firstByteCause = 5'h00;
  cmd_t cmd = '0;
  drive_ev_t ev = '0;
  logic rdStart, rdByte, rdDone, statusParity, statusValid, exception, readOk, done;
  logic [2:0] rdIndex;
  logic [7:0] statusByte;
  logic [5:0][7:0] stat;
  tape_pos_t tapePos;
  row_t rows[$];
  int mismatches = 0, n_compared = 0, k, n;
  logic [1:0] hp[5] = '{2'h0, 2'h1, 2'h3, 2'h2, 2'h3};
  tape_pos_t ep[5] = '{POS_START, POS_WARNING, POS_RECORD, POS_END, POS_RECORD};

  tape_drive_status_reporting tape_drive_status_reporting_inst (.clk(clk), .rst(rst),
    .hostResetPin(hostResetPin), .onLinePin(onLinePin), .upper_hole_n(upper_hole_n),
    .lower_hole_n(lower_hole_n), .trackZero(trackZero), .writeActive(writeActive), .readActive(readActive),
    .firstByteCause(firstByteCause), .cmd(cmd), .ev(ev), .rdStart(rdStart), .rdByte(rdByte),
    .rdIndex(rdIndex), .rdDone(rdDone), .statusByte(statusByte), .statusParity(statusParity),
    .statusValid(statusValid), .exception(exception), .tapePos(tapePos));
  host_status_reader host_status_reader_inst (.clk(clk), .go(go), .rdStart(rdStart), .rdByte(rdByte),
    .rdIndex(rdIndex), .rdDone(rdDone), .statusByte(statusByte), .statusParity(statusParity),
    .statusValid(statusValid), .stat(stat), .readOk(readOk), .done(done));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : stop_test

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  // One-cycle command or event, then one spare cycle for the update
  task automatic pulse(input cmd_t c, input drive_ev_t e);
    cmd = c;
    ev = e;
    @(negedge clk);
    cmd = '0;
    ev = '0;
    @(negedge clk);
  endtask : pulse

  task automatic read_status(input logic [7:0] b0, b1, ec, uc, input logic ex);
    go = 1'b1;
    @(negedge clk);
    go = 1'b0;
    k = 0;
    while (done !== 1'b1 && k < 30) begin
      @(negedge clk);
      k++;
    end
    check({15'h0, done & readOk}, 16'h1, "read handshake or parity");
    check({8'h0, stat[0]}, {8'h0, b0}, "byte 0");
    check({8'h0, stat[1]}, {8'h0, b1}, "byte 1");
    check({stat[2], stat[3]}, {8'h0, ec}, "error count");
    check({stat[4], stat[5]}, {8'h0, uc}, "underrun count");
    check({15'h0, exception}, {15'h0, ex}, "exception after read");
  endtask : read_status

  task automatic add(input logic [9:0] e, input logic v, input cmd_kind_t kd, input logic [3:0] m,
                     input logic [4:0] q, input logic [2:0] lv, input logic [7:0] b0, b1, ec, uc);
    rows.push_back('{e, v, kd, m, q, lv, b0, b1, ec, uc});
  endtask : add

  // Clock and watchdog
  initial begin
    forever #25 clk = ~clk;
  end
  initial begin
    repeat (6000) @(posedge clk);
    mismatches++;
    $display("test watchdog expired");
    stop_test();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (12) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    check({15'h0, exception}, 16'h1, "exception at reset");
    check({13'h0, tapePos}, {13'h0, POS_UNKNOWN}, "position at reset");
    check({7'h0, statusByte, statusParity}, 16'h1, "byte at reset");
    read_status(8'h00, 8'h81, 8'h0, 8'h0, 1'b0);
    read_status(8'h00, 8'h00, 8'h0, 8'h0, 1'b0);
    $display("test reset done");
    // Rows: event, command, {read, write, online}, expected bytes and counts
    add(10'h200, 0, CMD_SELECT, 4'h0, 5'h0, 3'h4, 8'h81, 8'h00, 8'h0, 8'h0);
    add(10'h200, 0, CMD_SELECT, 4'h0, 5'h0, 3'h0, 8'h00, 8'h00, 8'h0, 8'h0);
    add(10'h100, 0, CMD_SELECT, 4'h0, 5'h0, 3'h4, 8'h82, 8'h00, 8'h0, 8'h0);
    add(10'h080, 0, CMD_SELECT, 4'h0, 5'h0, 3'h0, 8'h00, 8'h90, 8'h0, 8'h0);
    add(10'h010, 0, CMD_SELECT, 4'h0, 5'h0, 3'h2, 8'h00, 8'h00, 8'h1, 8'h0);
    add(10'h010, 0, CMD_SELECT, 4'h0, 5'h0, 3'h2, 8'h00, 8'h00, 8'h2, 8'h0);
    add(10'h008, 0, CMD_SELECT, 4'h0, 5'h0, 3'h4, 8'h00, 8'h00, 8'h3, 8'h0);
    add(10'h008, 0, CMD_SELECT, 4'h0, 5'h0, 3'h0, 8'h00, 8'h00, 8'h3, 8'h0);
    add(10'h004, 0, CMD_SELECT, 4'h0, 5'h0, 3'h2, 8'h00, 8'h00, 8'h3, 8'h1);
    add(10'h004, 0, CMD_SELECT, 4'h0, 5'h0, 3'h4, 8'h00, 8'h00, 8'h3, 8'h2);
    add(10'h000, 1, CMD_SELECT, 4'h0, 5'h0, 3'h0, 8'h00, 8'hC0, 8'h3, 8'h2);
    add(10'h000, 1, CMD_SELECT, 4'h3, 5'h0, 3'h0, 8'h00, 8'hC0, 8'h3, 8'h2);
    add(10'h000, 1, CMD_POSITION, 4'h0, 5'h0, 3'h0, 8'h00, 8'hC0, 8'h3, 8'h2);
    add(10'h000, 1, CMD_WRITE, 4'h0, 5'h0, 3'h0, 8'h00, 8'hC0, 8'h3, 8'h2);
    add(10'h000, 1, CMD_WFM, 4'h0, 5'h0, 3'h0, 8'h00, 8'hC0, 8'h3, 8'h2);
    add(10'h000, 1, CMD_READ, 4'h0, 5'h0, 3'h0, 8'h00, 8'hC0, 8'h3, 8'h2);
    add(10'h000, 1, CMD_RFM, 4'h0, 5'h0, 3'h0, 8'h00, 8'hC0, 8'h3, 8'h2);
    add(10'h000, 1, CMD_UNIMPL, 4'h0, 5'h0, 3'h1, 8'h00, 8'hC0, 8'h3, 8'h2);
    add(10'h000, 1, CMD_READ, 4'h0, 5'h0, 3'h3, 8'h00, 8'hC0, 8'h3, 8'h2);
    add(10'h002, 0, CMD_SELECT, 4'h0, 5'h0, 3'h0, 8'h00, 8'hC0, 8'h3, 8'h2);
    add(10'h000, 1, CMD_OTHER, 4'h0, 5'h0, 3'h2, 8'h00, 8'hC0, 8'h3, 8'h2);
    add(10'h000, 1, CMD_SELECT, 4'h2, 5'h0, 3'h0, 8'h00, 8'h00, 8'h3, 8'h2);
    add(10'h000, 1, CMD_READ, 4'h0, 5'h0, 3'h5, 8'h00, 8'h00, 8'h3, 8'h2);
    foreach (rows[i]) begin
      {readActive, writeActive, onLinePin} = rows[i].lv;
      repeat (4) @(negedge clk);
      pulse('{rows[i].v, rows[i].k, rows[i].m, rows[i].q}, drive_ev_t'(rows[i].e));
      check({15'h0, exception}, {15'h0, |rows[i].b0 | |(rows[i].b1 & 8'hF7)}, "exception");
      read_status(rows[i].b0, rows[i].b1, rows[i].ec, rows[i].uc, 1'b0);
      $display("test row %0d done", i);
    end
    {readActive, writeActive, onLinePin} = 3'h0;
    firstByteCause = 5'h01;
    repeat (3) @(negedge clk);
    read_status(8'h84, 8'h00, 8'h3, 8'h2, 1'b1);
    firstByteCause = 5'h00;
    read_status(8'h00, 8'h00, 8'h3, 8'h2, 1'b0);
    $display("test outside cause done");
    readActive = 1'b1;
    repeat (31) pulse('0, drive_ev_t'(10'h020));
    check({15'h0, exception}, 16'h0, "no data at 31");
    pulse('0, drive_ev_t'(10'h020));
    check({15'h0, exception}, 16'h1, "no data at 32");
    read_status(8'h00, 8'hA0, 8'h3, 8'h2, 1'b0);
    readActive = 1'b0;
    $display("test no data done");
    trackZero = 1'b1;
    for (n = 0; n < 5; n++) begin
      {upper_hole_n, lower_hole_n} = hp[n];
      repeat (5) @(negedge clk);
      check({13'h0, tapePos}, {13'h0, ep[n]}, "position");
      if (n == 0) begin
        read_status(8'h00, 8'h88, 8'h3, 8'h2, 1'b0);
        pulse('0, drive_ev_t'(10'h002));
        read_status(8'h00, 8'h88, 8'h3, 8'h2, 1'b0);
      end
      if (n == 1) read_status(8'h00, 8'h00, 8'h3, 8'h2, 1'b0);
    end
    pulse('0, drive_ev_t'(10'h001));
    repeat (3) @(negedge clk);
    check({13'h0, tapePos}, {13'h0, POS_UNKNOWN}, "position after insertion");
    trackZero = 1'b0;
    $display("test position done");
    hostResetPin = 1'b1;
    repeat (3) @(negedge clk);
    hostResetPin = 1'b0;
    repeat (4) @(negedge clk);
    check({15'h0, exception}, 16'h1, "exception after host reset");
    read_status(8'h00, 8'h81, 8'h3, 8'h2, 1'b0);
    $display("test host reset done");
    stop_test();
  end
endmodule : tb_tape_drive_status_reporting
`default_nettype wire
